// file: include/bridge_parity_params.svh
// Offsets, field positions and reset values for the bridge parity/window block
`ifndef BRIDGE_PARITY_PARAMS_SVH
`define BRIDGE_PARITY_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte offsets in configuration space)
// ----------------------------------------------------------------
`define SEC_STATUS_OFFSET   8'h1e
`define MMIO_BASE_OFFSET    8'h20
`define MMIO_LIMIT_OFFSET   8'h22

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SEC_POISON_BIT      4'hf
`define SEC_MASTER_PAR_BIT  4'h8
`define WINDOW_FIELD_LSB    4
`define WINDOW_FIELD_MSB    15
`define ADDR_WINDOW_LSB     20
`define ADDR_WINDOW_MSB     31

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WINDOW_FIELD_RESET  12'h000
`define READ_IDLE_VALUE     16'h0000

`endif

// file: include/bridge_parity_pkg.sv
// Types shared by the bridge parity/window block
package bridge_parity_pkg;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef logic [11:0] window_field_t;

   typedef struct packed {
      logic          primary_poison_detected;
      logic          primary_master_parity_flag;
      logic          secondary_poison_detected;
      logic          secondary_master_parity_flag;
      window_field_t mmio_window_base;
      window_field_t mmio_window_limit;
      logic [15:0]   rdata;
      logic          rvalid;
      logic          fwd_valid;
      logic          fwd_hit;
   } bridge_state_t;

   typedef struct packed {
      logic req;
      logic hit;
   } decode_state_t;

endpackage : bridge_parity_pkg

// file: rtl/mmio_window_decode.sv
// Registered inclusive 1 MB-granular non-prefetchable window compare
`timescale 1ns/1ns
`include "bridge_parity_params.svh"
module mmio_window_decode
   import bridge_parity_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          reset_i,
   input  wire logic          req_i,
   input  wire logic [31:0]   addr_i,
   input  wire window_field_t base_i,
   input  wire window_field_t limit_i,
   output logic               valid_o,
   output logic               hit_o
);

   decode_state_t state;
   decode_state_t next_state;
   window_field_t page;

   // ----------------------------------------------------------------
   // Compare
   // ----------------------------------------------------------------
   // Only A[31:20] is compared: low base bits act as 00000h and low
   // limit bits as FFFFFh, so both ends fall on megabyte edges.
   always_comb begin
      page            = addr_i[`ADDR_WINDOW_MSB:`ADDR_WINDOW_LSB];
      next_state.req  = req_i;
      next_state.hit  = req_i && (base_i <= page) && (page <= limit_i);
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign valid_o = state.req;
   assign hit_o   = state.hit;

endmodule : mmio_window_decode

// file: rtl/bridge_parity_status.sv
// Secondary status high byte, parity matrix and non-prefetchable window base
//
// What this block does
// - With parity response enabled the secondary master parity flag would set on a poisoned completion received or a write poisoned by the port.
// - With parity response disabled the secondary master parity flag is never set.
// - The root port originates no requests, so the secondary master parity flag stays zero.
// - Secondary status bit 7 (fast back-to-back capable) reads zero and ignores writes.
// - Secondary status bit 5 (66 MHz capable) reads zero and ignores writes.
// - Status bit 6, status bits 4:0 and base bits 3:0 read zero and ignore writes.
// - Primary poison flag records outbound poisoned data, secondary poison flag records inbound, master parity flags never set.
// - Memory accesses inside the base/limit window are forwarded to the PCI Express port.
// - Base bits 15:4 are writable and compared against address bits 31:20.
// - The base low 20 address bits are taken as zero for decoding.
// - The limit low 20 address bits are taken as FFFFFh for decoding.
// - The base field sits in bits 15:4 of the register at offset 20h and resets to zero.
`timescale 1ns/1ns
`include "bridge_parity_params.svh"
module bridge_parity_status
   import bridge_parity_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        cfg_wr_i,
   input  wire logic        cfg_rd_i,
   input  wire logic [7:0]  cfg_addr_i,
   input  wire logic [15:0] cfg_wdata_i,
   input  wire logic [1:0]  cfg_be_i,
   input  wire logic        parity_response_enable_i,
   input  wire logic        primary_parity_response_enable_i,
   input  wire logic        outbound_poison_i,
   input  wire logic        inbound_poison_i,
   input  wire logic        completion_poison_rx_i,
   input  wire logic        write_poisoned_tx_i,
   input  wire logic        mem_req_i,
   input  wire logic [31:0] mem_addr_i,
   output logic [15:0]      cfg_rdata_o,
   output logic             cfg_rvalid_o,
   output logic             primary_poison_detected_o,
   output logic             primary_master_parity_flag_o,
   output logic             fwd_valid_o,
   output logic             fwd_hit_o
);

   bridge_state_t state;
   bridge_state_t next_state;
   logic          dec_valid;
   logic          dec_hit;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] merge_be(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  be);
      merge_be = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
   endfunction : merge_be

   // Sticky flag: a set in the same cycle as a clear wins
   function automatic logic w1c_flag(input logic cur, input logic set, input logic clr);
      w1c_flag = set | (cur & ~clr);
   endfunction : w1c_flag

   // ----------------------------------------------------------------
   // Window decoder
   // ----------------------------------------------------------------
   mmio_window_decode u_decode (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .req_i   (mem_req_i),
      .addr_i  (mem_addr_i),
      .base_i  (state.mmio_window_base),
      .limit_i (state.mmio_window_limit),
      .valid_o (dec_valid),
      .hit_o   (dec_hit)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic        wr_sec;
      logic        wr_base;
      logic        wr_lim;
      logic        sec_clr_poison;
      logic        sec_clr_master;
      logic        master_event;
      logic [15:0] merged;
      wr_sec         = cfg_wr_i && (cfg_addr_i == `SEC_STATUS_OFFSET);
      wr_base        = cfg_wr_i && (cfg_addr_i == `MMIO_BASE_OFFSET);
      wr_lim         = cfg_wr_i && (cfg_addr_i == `MMIO_LIMIT_OFFSET);
      sec_clr_poison = wr_sec && cfg_be_i[1] && cfg_wdata_i[`SEC_POISON_BIT];
      sec_clr_master = wr_sec && cfg_be_i[1] && cfg_wdata_i[`SEC_MASTER_PAR_BIT];
      merged         = 16'h0000;
      next_state     = state;

      // Poisoned completion in or poisoned write out, gated by parity response.
      // The port never requests, so both events stay idle in practice.
      master_event = parity_response_enable_i
                     && (completion_poison_rx_i || write_poisoned_tx_i);
      // Table forbids the master flag in this root port: the event is not recorded
      next_state.secondary_master_parity_flag =
         w1c_flag(state.secondary_master_parity_flag, master_event & 1'b0,
                  sec_clr_master);

      next_state.secondary_poison_detected =
         w1c_flag(state.secondary_poison_detected, inbound_poison_i, sec_clr_poison);
      // Primary flags live in the primary status register outside this map
      next_state.primary_poison_detected =
         w1c_flag(state.primary_poison_detected, outbound_poison_i, 1'b0);
      next_state.primary_master_parity_flag =
         1'b0 & primary_parity_response_enable_i;

      if (wr_base) begin
         merged = merge_be({state.mmio_window_base, 4'h0}, cfg_wdata_i, cfg_be_i);
         next_state.mmio_window_base = merged[`WINDOW_FIELD_MSB:`WINDOW_FIELD_LSB];
      end
      if (wr_lim) begin
         merged = merge_be({state.mmio_window_limit, 4'h0}, cfg_wdata_i, cfg_be_i);
         next_state.mmio_window_limit = merged[`WINDOW_FIELD_MSB:`WINDOW_FIELD_LSB];
      end

      next_state.rvalid = cfg_rd_i;
      next_state.rdata  = `READ_IDLE_VALUE;
      if (cfg_rd_i) begin
         case (cfg_addr_i)
            `SEC_STATUS_OFFSET: begin
               // Bits 7, 6, 5 and 4:0 are constant zero
               next_state.rdata = {state.secondary_poison_detected, 6'h00,
                                   state.secondary_master_parity_flag, 8'h00};
            end
            `MMIO_BASE_OFFSET: begin
               next_state.rdata = {state.mmio_window_base, 4'h0};
            end
            `MMIO_LIMIT_OFFSET: begin
               next_state.rdata = {state.mmio_window_limit, 4'h0};
            end
            default: begin
               next_state.rdata = `READ_IDLE_VALUE;
            end
         endcase
      end

      next_state.fwd_valid = dec_valid;
      next_state.fwd_hit   = dec_hit;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state                   <= '0;
         state.mmio_window_base  <= `WINDOW_FIELD_RESET;
         state.mmio_window_limit <= `WINDOW_FIELD_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign cfg_rdata_o                  = state.rdata;
   assign cfg_rvalid_o                 = state.rvalid;
   assign primary_poison_detected_o    = state.primary_poison_detected;
   assign primary_master_parity_flag_o = state.primary_master_parity_flag;
   assign fwd_valid_o                  = state.fwd_valid;
   assign fwd_hit_o                    = state.fwd_hit;

endmodule : bridge_parity_status

// file: testbench/bridge_parity_checker.sv
// Concurrent checks on the ports of the bridge parity status block
`timescale 1ns/1ns
module bridge_parity_checker (
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic        cfg_rd_i,
   input wire logic [7:0]  cfg_addr_i,
   input wire logic        outbound_poison_i,
   input wire logic        mem_req_i,
   input wire logic [15:0] cfg_rdata_o,
   input wire logic        cfg_rvalid_o,
   input wire logic        primary_poison_detected_o,
   input wire logic        primary_master_parity_flag_o,
   input wire logic        fwd_valid_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   a_read_answer: assert property (cfg_rd_i |=> cfg_rvalid_o)
      else $error("read not answered next cycle");
   a_answer_cause: assert property (cfg_rvalid_o |-> $past(cfg_rd_i))
      else $error("read data without a read");
   a_fwd_latency: assert property (mem_req_i |-> ##2 fwd_valid_o)
      else $error("decode result late or missing");
   a_fwd_cause: assert property (fwd_valid_o |-> $past(mem_req_i, 2))
      else $error("decode result without a request");
   a_master_flag_zero: assert property (!primary_master_parity_flag_o)
      else $error("primary master parity flag set");
   a_poison_sets: assert property (outbound_poison_i |=> primary_poison_detected_o)
      else $error("outbound poison not recorded");
   a_poison_sticky: assert property (primary_poison_detected_o |=> primary_poison_detected_o)
      else $error("primary poison flag dropped");
   a_status_low_zero: assert property (cfg_rd_i && cfg_addr_i == 8'h1e
      |=> cfg_rdata_o[14:0] == 15'h0000)
      else $error("status bits 14:0 not zero");
   a_base_nibble_zero: assert property (cfg_rd_i && cfg_addr_i == 8'h20
      |=> cfg_rdata_o[3:0] == 4'h0)
      else $error("base bits 3:0 not zero");
endmodule : bridge_parity_checker

bind bridge_parity_status bridge_parity_checker u_chk (.clk_i(clk_i), .reset_i(reset_i),
   .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .outbound_poison_i(outbound_poison_i),
   .mem_req_i(mem_req_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
   .primary_poison_detected_o(primary_poison_detected_o),
   .primary_master_parity_flag_o(primary_master_parity_flag_o), .fwd_valid_o(fwd_valid_o));

// file: testbench/pcie_link_partner.sv
// Behavioural link partner raising poison events toward the bridge
`timescale 1ns/1ns
module pcie_link_partner (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic [3:0] fire_i,
   output logic            inbound_poison_o,
   output logic            outbound_poison_o,
   output logic            completion_poison_o,
   output logic            write_poison_o
);
   // Registered so every event is a clean one-cycle pulse after the request
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         {write_poison_o, completion_poison_o, outbound_poison_o, inbound_poison_o} <= 4'h0;
      end else begin
         {write_poison_o, completion_poison_o, outbound_poison_o, inbound_poison_o} <= fire_i;
      end
   end
endmodule : pcie_link_partner

// file: testbench/tb_top.sv
// Self-checking bench for the bridge parity status block
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_top;
   logic        clk_i, reset_i, cfg_wr_i, cfg_rd_i, pre, ppre, mem_req_i, rv, pp, mp, fv, fh;
   logic        ib, ob, cp, wp, eh;
   logic [3:0]  fire;
   logic [7:0]  cfg_addr_i;
   logic [15:0] cfg_wdata_i, rd, ev;
   logic [1:0]  cfg_be_i;
   logic [31:0] mem_addr_i, r;
   logic [31:0] al [12];
   logic [11:0] b, l;
   logic [15:0] rq [$];
   logic        hq [$];
   int          fails, tests_run, cycles;

   bridge_parity_status u_dut (.clk_i(clk_i), .reset_i(reset_i), .cfg_wr_i(cfg_wr_i),
      .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_be_i(cfg_be_i),
      .parity_response_enable_i(pre), .primary_parity_response_enable_i(ppre),
      .outbound_poison_i(ob), .inbound_poison_i(ib), .completion_poison_rx_i(cp),
      .write_poisoned_tx_i(wp), .mem_req_i(mem_req_i), .mem_addr_i(mem_addr_i),
      .cfg_rdata_o(rd), .cfg_rvalid_o(rv), .primary_poison_detected_o(pp),
      .primary_master_parity_flag_o(mp), .fwd_valid_o(fv), .fwd_hit_o(fh));
   pcie_link_partner u_link (.clk_i(clk_i), .reset_i(reset_i), .fire_i(fire),
      .inbound_poison_o(ib), .outbound_poison_o(ob), .completion_poison_o(cp),
      .write_poison_o(wp));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task cfg(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [1:0] be,
            input logic [15:0] e);
      @(posedge clk_i);
      {cfg_wr_i, cfg_rd_i, cfg_addr_i, cfg_wdata_i, cfg_be_i} <= {w, !w, a, d, be};
      if (!w) rq.push_back(e);
      @(posedge clk_i);
      {cfg_wr_i, cfg_rd_i} <= 2'h0;
   endtask : cfg
   task poke(input logic [3:0] f);
      @(posedge clk_i);
      fire <= f;
      @(posedge clk_i);
      fire <= 4'h0;
      repeat (2) @(posedge clk_i);
   endtask : poke
   task final_report;
      if (fails == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report

   // ------------------------------------------------------------
   // Clock, monitor and hang guard
   // ------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (rv === 1'b1) begin
         ev = rq.size() ? rq.pop_front() : 16'hxxxx;
         `CHK("cfg_rdata_o", ev, rd)
      end
      if (fv === 1'b1) begin
         eh = hq.size() ? hq.pop_front() : 1'bx;
         `CHK("fwd_hit_o", eh, fh)
      end
      cycles++;
      if (cycles == 2000) begin
         fails++;
         final_report();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      r = $urandom(58590);
      {reset_i, cfg_wr_i, cfg_rd_i, cfg_addr_i, cfg_wdata_i, cfg_be_i} = {3'b100, 26'h0};
      {pre, ppre, fire, mem_req_i, mem_addr_i} = {2'b01, 4'h0, 1'b0, 32'h0};
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      foreach (al[i]) cfg(0, 8'h1e + 8'(i % 4) * 8'h02, 0, 0, 16'h0000);
      cfg(1, 8'h1e, 16'hffff, 2'h3, 0);
      cfg(0, 8'h1e, 0, 0, 16'h0000);
      for (int i = 0; i < 2; i++) begin
         pre  <= i[0];
         ppre <= i[0];
         poke(4'b1100);
         `CHK("primary_master_flag", 1'b0, mp)
         cfg(0, 8'h1e, 0, 0, 16'h0000);
      end
      poke(4'b0001);
      cfg(0, 8'h1e, 0, 0, 16'h8000);
      `CHK("primary_poison", 1'b0, pp)
      cfg(1, 8'h1e, 16'hffff, 2'h1, 0);
      cfg(0, 8'h1e, 0, 0, 16'h8000);
      cfg(1, 8'h1e, 16'h7eff, 2'h3, 0);
      cfg(0, 8'h1e, 0, 0, 16'h8000);
      cfg(1, 8'h1e, 16'h8000, 2'h2, 0);
      cfg(0, 8'h1e, 0, 0, 16'h0000);
      poke(4'b0010);
      `CHK("primary_poison", 1'b1, pp)
      cfg(0, 8'h1e, 0, 0, 16'h0000);
      cfg(1, 8'h20, 16'hffff, 2'h3, 0);
      cfg(0, 8'h20, 0, 0, 16'hfff0);
      cfg(1, 8'h20, 16'h0000, 2'h1, 0);
      cfg(0, 8'h20, 0, 0, 16'hff00);
      // Range keeps base-1 and limit+1 from wrapping
      b = 12'($urandom_range(12'h7ff, 12'h100));
      l = b + 12'($urandom_range(12'h1ff, 0));
      cfg(1, 8'h20, {b, 4'hf}, 2'h3, 0);
      cfg(1, 8'h22, {l, 4'h5}, 2'h3, 0);
      cfg(0, 8'h20, 0, 0, {b, 4'h0});
      cfg(0, 8'h22, 0, 0, {l, 4'h0});
      foreach (al[i]) al[i] = $urandom;
      al[0] = {b, 20'h00000};
      al[1] = {b - 12'h001, 20'hfffff};
      al[2] = {l, 20'hfffff};
      al[3] = {l + 12'h001, 20'h00000};
      al[4] = {32'h000fffff};
      foreach (al[i]) begin
         @(posedge clk_i);
         {mem_req_i, mem_addr_i} <= {1'b1, al[i]};
         hq.push_back(b <= al[i][31:20] && al[i][31:20] <= l);
      end
      @(posedge clk_i);
      mem_req_i <= 1'b0;
      // Mid-run reset must drop both poison flags and the window registers
      poke(4'b0011);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      `CHK("primary_poison", 1'b0, pp)
      cfg(0, 8'h1e, 0, 0, 16'h0000);
      cfg(0, 8'h20, 0, 0, 16'h0000);
      cfg(0, 8'h22, 0, 0, 16'h0000);
      repeat (5) @(posedge clk_i);
      `CHK("pending", 0, rq.size() + hq.size())
      final_report();
   end
endmodule : tb_top
